// [core/pdr_pkg.sv]
/*
 * Shared constants of the picture decode run control: register map, field
 * positions, reset values and the bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus and a frame engine beside the block.
 */


package pdr_pkg;
   // ***************************************************************
   // Register map, byte addresses.
   // ***************************************************************
   localparam logic [7:0] PDR_ADDR_CMD     = 8'h00;
   localparam logic [7:0] PDR_ADDR_PARAM   = 8'h04;
   localparam logic [7:0] PDR_ADDR_DELAY   = 8'h08;
   localparam logic [7:0] PDR_ADDR_STATUS  = 8'h0C;
   localparam logic [7:0] PDR_ADDR_DISP    = 8'h10;
   localparam logic [7:0] PDR_ADDR_INT_ST  = 8'h14;
   localparam logic [7:0] PDR_ADDR_INT_EN  = 8'h18;

   // ***************************************************************
   // Field positions.
   // ***************************************************************
   localparam int PDR_CMD_RUN_BIT      = 0;
   localparam int PDR_PAR_PRESCAN_BIT  = 0;
   localparam int PDR_PAR_MODE_BIT     = 1;
   localparam int PDR_PAR_KIND_BIT     = 2;
   localparam int PDR_PAR_SEARCH_BIT   = 3;
   localparam int PDR_PAR_FLUSH_BIT    = 4;
   localparam int PDR_PAR_COUNT_LSB    = 8;
   localparam int PDR_ST_BUSY_BIT      = 0;
   localparam int PDR_ST_CHECK_BIT     = 1;
   localparam int PDR_ST_STARTED_BIT   = 2;
   localparam int PDR_ST_DECIDX_LSB    = 16;
   localparam int PDR_INT_DONE_BIT     = 3;
   localparam int PDR_INT_EMPTY_BIT    = 4;

   // ***************************************************************
   // Reset values and codes.
   // ***************************************************************
   localparam logic [15:0] PDR_IDX_NONE    = 16'hFFFF;
   localparam logic [4:0]  PDR_DELAY_RST   = 5'h00;
   localparam logic [7:0]  PDR_COUNT_RST   = 8'h00;
   localparam logic [4:0]  PDR_INT_EN_RST  = 5'h00;
   localparam logic [1:0]  PDR_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PDR_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PDR_IDLE, PDR_HDR, PDR_BODY, PDR_DONE} pdr_state_t;
endpackage

// [core/pdr_top.sv]
/*
 * Picture decode run control: AXI4-Lite register slave and the run state
 * machine that decides between check, skip, search, decode and flush.
 * Assumes a frame engine that parses frame headers on request and reports
 * each processed frame, and a stream scanner that reports picture presence.
 */
`timescale 1ns/1ps

module pdr_top
   import pdr_pkg::*;
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Stream scanner.
   input  wire logic        pic_present,
   input  wire logic        stream_empty,
   // Frame engine.
   output logic             eng_frame_req,
   output logic             eng_go,
   output logic             eng_go_decode,
   input  wire logic        eng_hdr,
   input  wire logic        eng_hdr_intra,
   input  wire logic        eng_done,
   input  wire logic [15:0] eng_dec_index,
   input  wire logic [15:0] eng_disp_index,
   // Interrupt.
   output logic             irq
);
   import pdr_pkg::*;

   // ***************************************************************
   // Bus slave state.
   // ***************************************************************
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic        aw_have_q, w_have_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // Software registers and run state.
   logic [15:0] param_q;
   logic [4:0]  delay_q;
   logic [4:0]  int_st_q;
   logic [4:0]  int_en_q;
   logic        irq_q;
   pdr_state_t  state_q;
   logic        busy_q, started_q, check_q, primed_q, req_q;
   logic        search_q, kind_q, skip1_q, dec_frame_q, go_q, go_dec_q;
   logic [8:0]  skip_left_q;
   logic [4:0]  dec_left_q;
   logic [4:0]  stored_q;
   logic [15:0] dec_idx_q, disp_idx_q;

   // ***************************************************************
   // Decode of write and command.
   // ***************************************************************
   logic wr_fire, cmd_wr, accept, ar_fire, wr_mapped;
   logic p_pre, p_mode, p_kind, p_search, p_flush, pre_eff;
   logic [7:0] p_count;

   // A write fires once address and data are both held and no response waits.
   assign wr_fire   = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_mapped = awaddr_q == PDR_ADDR_CMD || awaddr_q == PDR_ADDR_PARAM ||
                      awaddr_q == PDR_ADDR_DELAY || awaddr_q == PDR_ADDR_INT_ST ||
                      awaddr_q == PDR_ADDR_INT_EN;
   assign cmd_wr    = wr_fire & (awaddr_q == PDR_ADDR_CMD) & wstrb_q[0] & wdata_q[PDR_CMD_RUN_BIT];
   // A run command while busy is dropped so the stored results stay intact.
   assign accept    = cmd_wr & (state_q == PDR_IDLE);
   assign ar_fire   = s_axi_arvalid & arready_q;

   // Parameters as latched before the command, sampled at acceptance.
   assign p_pre     = param_q[PDR_PAR_PRESCAN_BIT];
   assign p_mode    = param_q[PDR_PAR_MODE_BIT];
   assign p_kind    = param_q[PDR_PAR_KIND_BIT];
   assign p_search  = param_q[PDR_PAR_SEARCH_BIT];
   assign p_flush   = param_q[PDR_PAR_FLUSH_BIT];
   assign p_count   = param_q[PDR_PAR_COUNT_LSB +: 8];
   // Search overrides pre-scan; a single-frame skip forces it on.
   assign pre_eff   = ~p_search & (p_pre | (p_count == 8'h01));

   // ***************************************************************
   // AXI4-Lite write channels.
   // ***************************************************************
   // Address and data are taken independently and held until the write response is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= PDR_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && awready_q)
         begin
            aw_have_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q)
         begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            wready_q <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? PDR_RESP_OKAY : PDR_RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q  <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // AXI4-Lite read channel.
   // ***************************************************************
   // Reads return one cycle after the address is taken; reserved bits are zero.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= PDR_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= PDR_RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            PDR_ADDR_CMD:    rdata_q <= 32'h0000_0000;
            PDR_ADDR_PARAM:  rdata_q <= {16'h0000, param_q};
            PDR_ADDR_DELAY:  rdata_q <= {27'h0, delay_q};
            PDR_ADDR_STATUS: rdata_q <= {dec_idx_q, 13'h0, started_q, check_q, busy_q};
            PDR_ADDR_DISP:   rdata_q <= {16'h0000, disp_idx_q};
            PDR_ADDR_INT_ST: rdata_q <= {27'h0, int_st_q};
            PDR_ADDR_INT_EN: rdata_q <= {27'h0, int_en_q};
            default:
            begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= PDR_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ***************************************************************
   // Software registers.
   // ***************************************************************
   // Parameter and delay registers, written by byte lane.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         param_q  <= {PDR_COUNT_RST, 8'h00};
         delay_q  <= PDR_DELAY_RST;
         int_en_q <= PDR_INT_EN_RST;
      end
      else if (wr_fire)
      begin
         if (awaddr_q == PDR_ADDR_PARAM && wstrb_q[0])
            param_q[7:0] <= {3'b000, wdata_q[4:0]};
         if (awaddr_q == PDR_ADDR_PARAM && wstrb_q[1])
            param_q[15:8] <= wdata_q[15:8];
         if (awaddr_q == PDR_ADDR_DELAY && wstrb_q[0])
            delay_q <= (wdata_q[4:0] > 5'h10) ? 5'h10 : wdata_q[4:0];
         if (awaddr_q == PDR_ADDR_INT_EN && wstrb_q[0])
            int_en_q <= wdata_q[4:0];
      end
   end

   // Sticky interrupt bits, write one to clear; a new event wins over the clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_st_q <= 5'h00;
         irq_q    <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 5; i++)
         begin
            if (wr_fire && awaddr_q == PDR_ADDR_INT_ST && wstrb_q[0] && wdata_q[i])
               int_st_q[i] <= 1'b0;
         end
         if (state_q == PDR_DONE)
            int_st_q[PDR_INT_DONE_BIT] <= 1'b1;
         if (busy_q && stream_empty)
            int_st_q[PDR_INT_EMPTY_BIT] <= 1'b1;
         irq_q <= |(int_st_q & int_en_q);
      end
   end

   // ***************************************************************
   // Run state machine.
   // ***************************************************************
   // One run per command; each frame is header first, then a decode or discard go.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q     <= PDR_IDLE;
         busy_q      <= 1'b0;
         started_q   <= 1'b0;
         check_q     <= 1'b0;
         primed_q    <= 1'b0;
         search_q    <= 1'b0;
         kind_q      <= 1'b0;
         skip1_q     <= 1'b0;
         dec_frame_q <= 1'b0;
         go_q        <= 1'b0;
         go_dec_q    <= 1'b0;
         req_q       <= 1'b0;
         skip_left_q <= 9'h000;
         dec_left_q  <= 5'h00;
         stored_q    <= 5'h00;
         dec_idx_q   <= PDR_IDX_NONE;
         disp_idx_q  <= PDR_IDX_NONE;
      end
      else
      begin
         go_q <= 1'b0;
         case (state_q)
            PDR_IDLE:
            begin
               if (accept)
               begin
                  busy_q    <= 1'b1;
                  started_q <= 1'b0;
                  dec_idx_q <= PDR_IDX_NONE;
                  if (p_flush)
                  begin
                     // Hand out one stored picture, minus one once none is left.
                     disp_idx_q <= (stored_q != 5'h00) ? {11'h000, stored_q - 5'h01} : PDR_IDX_NONE;
                     stored_q   <= (stored_q != 5'h00) ? stored_q - 5'h01 : 5'h00;
                     primed_q   <= primed_q & (stored_q != 5'h00);
                     started_q  <= 1'b1;
                     state_q    <= PDR_DONE;
                  end
                  else if (pre_eff && !pic_present)
                  begin
                     check_q   <= 1'b0;
                     started_q <= 1'b1;
                     state_q   <= PDR_DONE;
                  end
                  else if (pre_eff && p_mode && p_count != 8'h01)
                  begin
                     check_q   <= 1'b1;
                     started_q <= 1'b1;
                     state_q   <= PDR_DONE;
                  end
                  else
                  begin
                     // Decode starts automatically; mode 1 with a forced check still skips.
                     check_q     <= 1'b1;
                     search_q    <= p_search;
                     kind_q      <= p_kind & ~p_search;
                     skip1_q     <= ~p_search & ~p_kind & (p_count == 8'h01);
                     skip_left_q <= p_search ? {1'b0, p_count} + 9'h001 : {1'b0, p_count};
                     // The first reordering run fills every reorder slot.
                     dec_left_q  <= (delay_q != 5'h00 && !primed_q) ? delay_q + 5'h01 : 5'h01;
                     req_q       <= 1'b1;
                     state_q     <= PDR_HDR;
                  end
               end
            end
            PDR_HDR:
            begin
               if (eng_hdr)
               begin
                  go_q      <= 1'b1;
                  started_q <= 1'b1;
                  if (search_q)
                  begin
                     // Only the (N+1)-th intra frame is decoded.
                     go_dec_q    <= eng_hdr_intra && skip_left_q == 9'h001;
                     skip_left_q <= eng_hdr_intra ? skip_left_q - 9'h001 : skip_left_q;
                     search_q    <= ~(eng_hdr_intra && skip_left_q == 9'h001);
                  end
                  else if (kind_q)
                  begin
                     go_dec_q <= eng_hdr_intra;
                     kind_q   <= ~eng_hdr_intra;
                  end
                  else if (skip_left_q != 9'h000)
                  begin
                     go_dec_q    <= 1'b0;
                     skip_left_q <= skip_left_q - 9'h001;
                  end
                  else
                     go_dec_q <= 1'b1;
                  dec_frame_q <= 1'b0;
                  req_q       <= 1'b0;
                  state_q     <= PDR_BODY;
               end
            end
            PDR_BODY:
            begin
               dec_frame_q <= go_q ? go_dec_q : dec_frame_q;
               if (eng_done && !go_q)
               begin
                  if (dec_frame_q)
                  begin
                     dec_idx_q  <= eng_dec_index;
                     disp_idx_q <= eng_disp_index;
                     dec_left_q <= dec_left_q - 5'h01;
                     if (dec_left_q == 5'h01)
                     begin
                        // Completion only after the wanted frame is decoded.
                        primed_q <= delay_q != 5'h00;
                        stored_q <= delay_q;
                        state_q  <= PDR_DONE;
                     end
                     else
                     begin
                        req_q   <= 1'b1;
                        state_q <= PDR_HDR;
                     end
                  end
                  else if (skip1_q && skip_left_q == 9'h000)
                  begin
                     check_q <= 1'b1;
                     state_q <= PDR_DONE;
                  end
                  else
                  begin
                     req_q   <= 1'b1;
                     state_q <= PDR_HDR;
                  end
               end
            end
            PDR_DONE:
            begin
               busy_q  <= 1'b0;
               state_q <= PDR_IDLE;
            end
            default:
               state_q <= PDR_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Outputs.
   // ***************************************************************
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign eng_frame_req = req_q;   // Registered so the engine never sees a decode glitch.
   assign eng_go        = go_q;
   assign eng_go_decode = go_dec_q;
   assign irq           = irq_q;

   // ***************************************************************
   // Assertions.
   // ***************************************************************
   busy_until_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(busy_q) |-> $past(state_q == PDR_DONE))
      else $error("busy dropped outside completion");
   done_irq_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(busy_q) |-> int_st_q[PDR_INT_DONE_BIT])
      else $error("completion bit not set with busy fall");
   prescan_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !p_flush && pre_eff && !pic_present |=> state_q == PDR_DONE && !check_q ##1 !busy_q)
      else $error("run without picture did not end at once");
   check_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !p_flush && pre_eff && p_mode && p_count != 8'h01 && pic_present
      |=> check_q && state_q == PDR_DONE && !go_q)
      else $error("check-only run did not finish with result");
   search_no_prescan_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !p_flush && p_search |=> state_q == PDR_HDR)
      else $error("intra search honoured pre-scan");
   kind_discard_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == PDR_HDR && eng_hdr && kind_q && !search_q |=> go_q && go_dec_q == $past(eng_hdr_intra))
      else $error("skip kind decision wrong");
   search_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == PDR_HDR && eng_hdr && search_q && eng_hdr_intra && skip_left_q == 9'h001
      |=> go_q && go_dec_q && !search_q)
      else $error("target intra frame not decoded");
   flush_no_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && p_flush |=> dec_idx_q == PDR_IDX_NONE && state_q == PDR_DONE && !go_q)
      else $error("flush run touched the decoder");
   first_fill_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !p_flush && !pre_eff && delay_q != 5'h00 && !primed_q
      |=> dec_left_q == $past(delay_q) + 5'h01)
      else $error("first reordering run frame count wrong");
   search_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == PDR_DONE && $past(state_q == PDR_BODY) && !skip1_q |-> $past(dec_frame_q && eng_done))
      else $error("run completed before decoding");
endmodule

// [tb/pdr_eng_model.sv]
/* Frame engine model for the run control bench.
   Assumes the header, go and done handshake of the control block. */
`timescale 1ns/1ps
module pdr_eng_model
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Requests from the control block.
   input  wire logic        eng_frame_req,
   input  wire logic        eng_go,
   // Answers to the control block.
   output logic             eng_hdr,
   output logic             eng_hdr_intra,
   output logic             eng_done,
   output logic [15:0]      eng_dec_index
);
   logic [15:0] n_q;
   logic        w_q;
   // Every third frame is intra; done comes two cycles after go, never in it.
   // Between answers the qualifiers show inverted values, so stale reads show up.
   always_ff @(posedge aclk)
   begin
      eng_hdr <= 1'b0;
      eng_done <= 1'b0;
      eng_dec_index <= w_q ? n_q : ~n_q;
      eng_hdr_intra <= ~eng_hdr_intra;
      if (!aresetn)
      begin
         n_q <= 16'h0000;
         w_q <= 1'b0;
         eng_hdr_intra <= 1'b0;
      end
      else
      begin
         if (eng_frame_req && !eng_hdr && !w_q)
         begin
            eng_hdr <= 1'b1;
            eng_hdr_intra <= (n_q % 3 == 2);
         end
         if (eng_go)
            w_q <= 1'b1;
         if (w_q)
         begin
            eng_done <= 1'b1;
            w_q <= 1'b0;
            n_q <= n_q + 16'h0001;
         end
      end
   end
endmodule

// [tb/tb_pdr_top.sv]
/* Self-checking bench of the run control: AXI4-Lite host tasks and runs.
   Assumes the frame engine model; it counts every frame the engine sees. */
`timescale 1ns/1ps
module tb_pdr_top;
   import pdr_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pic_present, stream_empty, irq;
   logic        eng_frame_req, eng_go, eng_go_decode, eng_hdr, eng_hdr_intra, eng_done;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, st, ist, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [15:0] eng_dec_index;
   int          bad_count, n_compared, n_all, n_dec, n_dis, i;
   pdr_top pdr_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pic_present, .stream_empty,
      .eng_frame_req, .eng_go, .eng_go_decode, .eng_hdr, .eng_hdr_intra, .eng_done, .eng_dec_index,
      .eng_disp_index(eng_dec_index), .irq);
   pdr_eng_model pdr_eng_model_i (.aclk, .aresetn, .eng_frame_req, .eng_go, .eng_hdr, .eng_hdr_intra, .eng_done,
      .eng_dec_index);
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("Compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // A wait that used up its bound ends the run as a mismatch.
   task automatic lim(input int t);
      if (t >= 60)
      begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (t = 0; t < 60; t++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      lim(t);
   endtask
   task automatic rd(input logic [7:0] a);
      int t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (t = 0; t < 60; t++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      lim(t);
   endtask
   // Frames discarded before the (n+1)-th intra frame, counted from frame b.
   function automatic int skips(input int b, input int n);
      int k;
      int c;
      c = 0;
      for (k = 0; c <= n; k++) if ((b + k) % 3 == 2) c++;
      return k - 1;
   endfunction
   // One run: issue, poll busy until low, check frame counts and the done interrupt.
   task automatic run(input logic [31:0] p, input int ed, input int ex);
      int t;
      wr(PDR_ADDR_PARAM, p);
      n_dec = 0;
      n_dis = 0;
      wr(PDR_ADDR_CMD, 32'h0000_0001);
      d = 32'h0000_0001;
      for (t = 0; t < 60 && d[PDR_ST_BUSY_BIT]; t++) rd(PDR_ADDR_STATUS);
      lim(t);
      st = d;
      chk("decoded", n_dec, ed);
      chk("discarded", n_dis, ex);
      chk("irq", irq, 1'b1);
      rd(PDR_ADDR_INT_ST);
      ist = d;
      chk("done_int", ist & 32'h0000_0008, 32'h0000_0008);
      wr(PDR_ADDR_INT_ST, 32'h0000_0018);
   endtask
   always @(posedge aclk)
      if (eng_go)
      begin
         n_all++;
         if (eng_go_decode) n_dec++;
         else n_dis++;
      end
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial
   begin
      // Response readies stay high so no task lowers and raises them in one step.
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, stream_empty} = 5'h00;
      {s_axi_bready, s_axi_rready} = 2'b11;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pic_present} = 49'h0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(PDR_ADDR_STATUS);
      chk("status_rst", d, 32'hFFFF_0000);
      rd(8'h1C);
      chk("unmapped", r, PDR_RESP_SLVERR);
      wr(8'h1C, 32'h0000_0000);
      chk("wr_unmapped", r, PDR_RESP_SLVERR);
      wr(PDR_ADDR_INT_EN, 32'h0000_0008);
      chk("wr_okay", r, PDR_RESP_OKAY);
      run(32'h0000_0001, 0, 0);
      chk("check_none", st[PDR_ST_CHECK_BIT], 1'b0);
      pic_present <= 1'b1;
      run(32'h0000_0003, 0, 0);
      chk("check_only", st[PDR_ST_CHECK_BIT], 1'b1);
      run(32'h0000_0001, 1, 0);
      wr(PDR_ADDR_DELAY, 32'h0000_0002);
      run(32'h0000_0000, 3, 0);
      run(32'h0000_0000, 1, 0);
      for (i = 1; i >= -1; i--)
      begin
         run(32'h0000_0010, 0, 0);
         chk("dec_idx", st[31:16], PDR_IDX_NONE);
         rd(PDR_ADDR_DISP);
         chk("disp_idx", d[15:0], i[15:0]);
      end
      $display("Flush and decode runs done");
      run(32'h0000_0100, 0, 1);
      chk("skip_check", st[PDR_ST_CHECK_BIT], 1'b1);
      // The flush emptied the reorder store, so this run refills delay plus one frames.
      run(32'h0000_0300, 3, 3);
      run(32'h0000_0004, 1, skips(n_all, 0));
      pic_present <= 1'b0;
      stream_empty <= 1'b1;
      run(32'h0000_010B, 1, skips(n_all, 1));
      stream_empty <= 1'b0;
      chk("empty_int", ist & 32'h0000_0010, 32'h0000_0010);
      rd(PDR_ADDR_INT_ST);
      chk("int_clear", d, 32'h0000_0000);
      chk("irq_low", irq, 1'b0);
      $display("Skip and search runs done");
      stop_test();
   end
endmodule
